// >>> hw/pfs_freq_select.sv
// Purpose: Register file and code selection for the programmable CPU clock synthesizer.
// Assumes: The serial-bus protocol engine hands over decoded byte reads and writes.
// Notes: Strap pins are sampled once, in the first cycle after reset is released.
//
// Overview of operation
// RL1: Enable set: CPU frequency from N and M.
// RL2: Writing M starts frequency load immediately.
// RL3: Override clear: ratio from latched strap code.
// RL4: Override set: ratio from software code.
// RL5: Programmable CPU range is 50 to 248 MHz.
// RL6: Enable is M bit 7, resets disabled.
// RL7: Software writes ones to reserved low bits.
// RL8: Fixed table decodes code to output frequencies.
// RL9: Codes 10000..10010 reserved, define no frequency.
// RL10: Software writes N and M together.
// RL11: Enable clear: frequency from strap or software.
// RL12: N register resets zero, fully read/write.
`timescale 1ns/10ps
`include "pfs_regs.svh"
module pfs_freq_select
    import pfs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] strapFrequencyCode,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    output logic [7:0] cpuDividerNValue,
    output logic [6:0] cpuDividerMValue,
    output logic customFreqEnable,
    output logic freqLoadPulse,
    output logic [4:0] activeCode,
    output logic softSourceActive,
    output logic [11:0] cpuFreqTenths,
    output logic [11:0] midRateClockGroupTenths,
    output logic [11:0] pciFreqTenths,
    output logic tableValid,
    output logic [22:0] gearConstant
);

    // ======================================================================
    // Register state
    logic [7:0] nValue_reg;
    logic [7:0] nValue_next;
    logic [7:0] mValue_reg;
    logic [7:0] mValue_next;
    logic [7:0] rsvdA_reg;
    logic [7:0] rsvdA_next;
    logic [7:0] rsvdB_reg;
    logic [7:0] rsvdB_next;
    logic [7:0] rsvdC_reg;
    logic [7:0] rsvdC_next;
    logic [7:0] selCtrl_reg;
    logic [7:0] selCtrl_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic rdValid_reg;
    logic rdValid_next;
    logic load_reg;
    logic load_next;
    logic wrN;
    logic wrM;

    // Strap and code selection state.
    pfs_strap_state_t strapState_reg;
    pfs_strap_state_t strapState_next;
    logic [4:0] strapLatched_reg;
    logic [4:0] strapLatched_next;
    logic [4:0] code_reg;
    logic [4:0] code_next;
    pfs_code_src_t src_reg;
    pfs_code_src_t src_next;

    // Frequency table output.
    logic romValid;

    // ======================================================================
    // Helpers
    function automatic logic isReservedCode(input logic [4:0] c);
        isReservedCode = (c == 5'h10) || (c == 5'h11) || (c == 5'h12);
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign wrN = regWrEn && hit(regAddr, `PFS_OFF_N_VALUE);
    assign wrM = regWrEn && hit(regAddr, `PFS_OFF_M_VALUE);

    // ======================================================================
    // Register writes. Every writable byte but the select control (top two bits cleared) is stored whole;
    // reserved bytes keep what is written so a read-back shows software honoured the fixed pattern.
    always_comb begin
        nValue_next = nValue_reg;
        mValue_next = mValue_reg;
        rsvdA_next = rsvdA_reg;
        rsvdB_next = rsvdB_reg;
        rsvdC_next = rsvdC_reg;
        selCtrl_next = selCtrl_reg;
        if (wrN) begin
            nValue_next = regWrData; // RL12
        end
        if (wrM) begin
            mValue_next = regWrData; // RL6
        end
        if (regWrEn && hit(regAddr, `PFS_OFF_RSVD_A)) begin
            rsvdA_next = regWrData; // RL7
        end
        if (regWrEn && hit(regAddr, `PFS_OFF_RSVD_B)) begin
            rsvdB_next = regWrData;
        end
        if (regWrEn && hit(regAddr, `PFS_OFF_RSVD_C)) begin
            rsvdC_next = regWrData;
        end
        if (regWrEn && hit(regAddr, `PFS_OFF_SEL_CTRL)) begin
            selCtrl_next = {2'b00, regWrData[5:0]};
        end
    end

    // Only the M byte triggers a load; software writes N first, M last.
    always_comb begin
        load_next = wrM; // RL2 RL10
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nValue_reg <= `PFS_RST_N_VALUE; // RL12
            mValue_reg <= `PFS_RST_M_VALUE; // RL6
            rsvdA_reg <= `PFS_RST_RSVD_A; // RL7
            rsvdB_reg <= `PFS_RST_RSVD_B;
            rsvdC_reg <= `PFS_RST_RSVD_C;
            selCtrl_reg <= `PFS_RST_SEL_CTRL;
            load_reg <= 1'b0;
        end else begin
            nValue_reg <= nValue_next;
            mValue_reg <= mValue_next;
            rsvdA_reg <= rsvdA_next;
            rsvdB_reg <= rsvdB_next;
            rsvdC_reg <= rsvdC_next;
            selCtrl_reg <= selCtrl_next;
            load_reg <= load_next;
        end
    end

    // ======================================================================
    // Register reads: one cycle latency, unmapped offsets read as zero.
    always_comb begin
        rdValid_next = regRdEn;
        rdData_next = rdData_reg;
        if (regRdEn) begin
            unique case (regAddr)
                `PFS_OFF_N_VALUE: rdData_next = nValue_reg;
                `PFS_OFF_M_VALUE: rdData_next = mValue_reg;
                `PFS_OFF_RSVD_A: rdData_next = rsvdA_reg;
                `PFS_OFF_RSVD_B: rdData_next = rsvdB_reg;
                `PFS_OFF_RSVD_C: rdData_next = rsvdC_reg;
                `PFS_OFF_SEL_CTRL: rdData_next = selCtrl_reg;
                `PFS_OFF_STATUS: rdData_next = {romValid, mValue_reg[`PFS_M_ENABLE_BIT],
                                                 1'b0, strapLatched_reg};
                default: rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_reg <= 8'h00;
            rdValid_reg <= 1'b0;
        end else begin
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
        end
    end

    // ======================================================================
    // Strap capture. The pins are taken after reset is gone rather than
    // under it, so reset only ever loads constants.
    always_comb begin
        strapState_next = strapState_reg;
        strapLatched_next = strapLatched_reg;
        unique case (strapState_reg)
            PFS_STRAP_WAIT: begin
                strapLatched_next = strapFrequencyCode;
                strapState_next = PFS_STRAP_RUN;
            end
            PFS_STRAP_RUN: begin
                strapState_next = PFS_STRAP_RUN;
            end
            default: begin
                strapState_next = PFS_STRAP_WAIT;
            end
        endcase
    end

    // Code source: strap latch unless the override bit picks software bits.
    // Reserved codes pass through; the table then reports no valid entry.
    always_comb begin
        if (selCtrl_reg[`PFS_SEL_OVERRIDE_BIT]) begin
            code_next = selCtrl_reg[4:0]; // RL4 RL11
            src_next = PFS_SRC_SOFT;
        end else begin
            code_next = strapLatched_next; // RL3 RL11
            src_next = PFS_SRC_STRAP;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strapState_reg <= PFS_STRAP_WAIT;
            strapLatched_reg <= 5'h00;
            code_reg <= 5'h00;
            src_reg <= PFS_SRC_STRAP;
        end else begin
            strapState_reg <= strapState_next;
            strapLatched_reg <= strapLatched_next;
            code_reg <= code_next;
            src_reg <= src_next;
        end
    end

    // ======================================================================
    // Decode table; it also sets ratio and gear constant in custom mode.
    pfs_freq_rom u_rom (
        .clk(clk),
        .rst_n(rst_n),
        .code(code_reg), // RL8
        .cpuTenths(cpuFreqTenths),
        .midTenths(midRateClockGroupTenths),
        .pciTenths(pciFreqTenths),
        .entryValid(romValid) // RL9
    );

    // ======================================================================
    // Outputs. In custom mode the PLL takes N and M; the table result still
    // fixes the ratio of the slower groups.
    assign cpuDividerNValue = nValue_reg; // RL1
    assign cpuDividerMValue = mValue_reg[6:0]; // RL1
    assign customFreqEnable = mValue_reg[`PFS_M_ENABLE_BIT]; // RL1 RL6
    assign freqLoadPulse = load_reg; // RL2
    assign activeCode = code_reg;
    assign softSourceActive = (src_reg == PFS_SRC_SOFT);
    assign tableValid = romValid;
    assign gearConstant = romValid ? `PFS_GEAR_CONST : 23'h0; // RL8
    assign regRdData = rdData_reg;
    assign regRdValid = rdValid_reg;

    // ======================================================================
    // Checks
    sequence mWriteSeq;
        regWrEn && (regAddr == `PFS_OFF_M_VALUE);
    endsequence

    sequence loadSeq;
        freqLoadPulse && customFreqEnable == $past(regWrData[7]);
    endsequence

    chk_m_write_load: assert property (@(posedge clk) disable iff (!rst_n) // RL2
        mWriteSeq |=> loadSeq ##1 !freqLoadPulse || $past(wrM))
        else $error("M write did not load the new frequency once");

    // Writing N alone must leave the synthesizer where it is.
    chk_n_no_load: assert property (@(posedge clk) disable iff (!rst_n) // RL2
        regWrEn && regAddr == `PFS_OFF_N_VALUE |=> !freqLoadPulse)
        else $error("N write started a frequency load");

    // Every valid table entry carries the same gear constant.
    chk_gear_valid: assert property (@(posedge clk) disable iff (!rst_n) // RL8
        tableValid |-> gearConstant == `PFS_GEAR_CONST)
        else $error("gear constant missing for a valid code");

    chk_enable_reset: assert property (@(posedge clk) // RL6
        !rst_n |=> !customFreqEnable && cpuDividerMValue == 7'h00)
        else $error("custom enable not cleared by reset");

    chk_n_write: assert property (@(posedge clk) disable iff (!rst_n) // RL12
        regWrEn && regAddr == `PFS_OFF_N_VALUE |=> cpuDividerNValue == $past(regWrData))
        else $error("N value not stored");

    chk_strap_source: assert property (@(posedge clk) disable iff (!rst_n) // RL3
        strapState_reg == PFS_STRAP_RUN && !selCtrl_reg[5] |=> activeCode == strapLatched_reg)
        else $error("strap code not selected");

    chk_soft_source: assert property (@(posedge clk) disable iff (!rst_n) // RL4
        selCtrl_reg[5] |=> activeCode == $past(selCtrl_reg[4:0]) && softSourceActive)
        else $error("software code not selected");

    chk_reserved_code: assert property (@(posedge clk) disable iff (!rst_n) // RL9
        isReservedCode(activeCode) |=> !tableValid && gearConstant == 23'h0)
        else $error("reserved code produced a frequency");

    chk_table_ends: assert property (@(posedge clk) disable iff (!rst_n) // RL8
        activeCode == 5'h1f |=> cpuFreqTenths == 12'd1333 && pciFreqTenths == 12'd333)
        else $error("table entry for top code wrong");

    chk_table_range: assert property (@(posedge clk) disable iff (!rst_n) // RL5
        tableValid |-> cpuFreqTenths <= `PFS_CPU_MAX_TENTHS && cpuFreqTenths >= 12'd666)
        else $error("table frequency outside supported range");

    chk_read_latency: assert property (@(posedge clk) disable iff (!rst_n) // RL12
        regRdEn && regAddr == `PFS_OFF_N_VALUE && !regWrEn |=> regRdValid
            && regRdData == $past(nValue_reg))
        else $error("N read-back wrong");

endmodule

// >>> hw/pfs_regs.svh
// Purpose: Offsets, field positions, reset values and constants of the CPU frequency selector.
// Assumes: Byte-wide registers reached by their serial-bus command offsets.
// Notes: Frequencies are carried in tenths of a MHz.
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH

// ==========================================================================
// Register offsets
`define PFS_OFF_N_VALUE 8'h0d
`define PFS_OFF_M_VALUE 8'h0e
`define PFS_OFF_RSVD_A 8'h0f
`define PFS_OFF_RSVD_B 8'h10
`define PFS_OFF_RSVD_C 8'h11
`define PFS_OFF_SEL_CTRL 8'h12
`define PFS_OFF_STATUS 8'h13

// ==========================================================================
// Field positions
`define PFS_M_ENABLE_BIT 7
`define PFS_SEL_OVERRIDE_BIT 5
`define PFS_STATUS_VALID_BIT 7
`define PFS_STATUS_CUSTOM_BIT 6

// ==========================================================================
// Reset values
`define PFS_RST_N_VALUE 8'h00
`define PFS_RST_M_VALUE 8'h00
`define PFS_RST_RSVD_A 8'h03
`define PFS_RST_RSVD_B 8'h00
`define PFS_RST_RSVD_C 8'h00
`define PFS_RST_SEL_CTRL 8'h00

// ==========================================================================
// Frequency limits of the programmable path and the gear constant (x 1e5).
`define PFS_CPU_MIN_TENTHS 12'h1f4
`define PFS_CPU_MAX_TENTHS 12'h9b0
`define PFS_GEAR_CONST 23'h4940e5

`endif

// >>> hw/pfs_pkg.sv
// Purpose: Types shared by the CPU frequency selector files.
// Assumes: Nothing beyond the register header.
// Notes: Holds types only; numbers live in the header.
package pfs_pkg;

    // ======================================================================
    // Strap capture sequence, one-hot.
    typedef enum logic [1:0] {
        PFS_STRAP_WAIT = 2'b01,
        PFS_STRAP_RUN = 2'b10
    } pfs_strap_state_t;

    // Origin of the active frequency code.
    typedef enum logic [1:0] {
        PFS_SRC_STRAP = 2'b01,
        PFS_SRC_SOFT = 2'b10
    } pfs_code_src_t;

endpackage

// >>> hw/pfs_freq_rom.sv
// Purpose: Fixed decode table from 5-bit frequency code to output frequencies.
// Assumes: Code is stable for one clock before the result is used.
// Notes: Results come out of registers, one cycle after the code.
`timescale 1ns/10ps
module pfs_freq_rom
    import pfs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] code,
    output logic [11:0] cpuTenths,
    output logic [11:0] midTenths,
    output logic [11:0] pciTenths,
    output logic entryValid
);

    logic [36:0] entryNext;
    logic [36:0] entry_reg;

    // ======================================================================
    // Table: {valid, cpu, mid, pci}; reserved codes give an invalid entry.
    function automatic logic [36:0] lookup(input logic [4:0] c);
        unique case (c)
            5'h00: lookup = {1'b1, 12'd1560, 12'd780, 12'd390};
            5'h01: lookup = {1'b1, 12'd1540, 12'd770, 12'd385};
            5'h02: lookup = {1'b1, 12'd1520, 12'd760, 12'd380};
            5'h03: lookup = {1'b1, 12'd1470, 12'd735, 12'd368};
            5'h04: lookup = {1'b1, 12'd1440, 12'd720, 12'd360};
            5'h05: lookup = {1'b1, 12'd1420, 12'd710, 12'd355};
            5'h06: lookup = {1'b1, 12'd1380, 12'd690, 12'd345};
            5'h07: lookup = {1'b1, 12'd1360, 12'd680, 12'd340};
            5'h08: lookup = {1'b1, 12'd1240, 12'd620, 12'd310};
            5'h09: lookup = {1'b1, 12'd1220, 12'd610, 12'd305};
            5'h0a: lookup = {1'b1, 12'd1170, 12'd780, 12'd390};
            5'h0b: lookup = {1'b1, 12'd1150, 12'd767, 12'd383};
            5'h0c: lookup = {1'b1, 12'd1130, 12'd753, 12'd377};
            5'h0d: lookup = {1'b1, 12'd1080, 12'd720, 12'd360};
            5'h0e: lookup = {1'b1, 12'd1050, 12'd700, 12'd350};
            5'h0f: lookup = {1'b1, 12'd1020, 12'd680, 12'd340};
            5'h10, 5'h11, 5'h12: lookup = 37'h0;
            5'h13: lookup = {1'b1, 12'd2000, 12'd666, 12'd333};
            5'h14: lookup = {1'b1, 12'd1900, 12'd760, 12'd380};
            5'h15: lookup = {1'b1, 12'd1800, 12'd720, 12'd360};
            5'h16: lookup = {1'b1, 12'd1700, 12'd680, 12'd340};
            5'h17: lookup = {1'b1, 12'd1500, 12'd750, 12'd375};
            5'h18: lookup = {1'b1, 12'd1400, 12'd700, 12'd350};
            5'h19: lookup = {1'b1, 12'd1200, 12'd600, 12'd300};
            5'h1a: lookup = {1'b1, 12'd1100, 12'd733, 12'd333};
            5'h1b: lookup = {1'b1, 12'd666, 12'd666, 12'd333};
            5'h1c: lookup = {1'b1, 12'd2000, 12'd666, 12'd333};
            5'h1d: lookup = {1'b1, 12'd1666, 12'd666, 12'd333};
            5'h1e: lookup = {1'b1, 12'd1000, 12'd666, 12'd333};
            5'h1f: lookup = {1'b1, 12'd1333, 12'd666, 12'd333};
        endcase
    endfunction

    // Registered read so the result never glitches while the code moves.
    always_comb begin
        entryNext = lookup(code);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            entry_reg <= 37'h0;
        end else begin
            entry_reg <= entryNext;
        end
    end

    assign entryValid = entry_reg[36];
    assign cpuTenths = entry_reg[35:24];
    assign midTenths = entry_reg[23:12];
    assign pciTenths = entry_reg[11:0];

endmodule

// >>> verification/pfs_freq_select_bench.sv
// Purpose: Self-checking bench for the CPU frequency selector register file and code decode.
// Assumes: Byte reads and writes arrive already decoded from the serial bus.
// Notes: Table rows are in tenths of a MHz; reserved codes expect all-zero, invalid results.
`timescale 1ns/10ps
`include "pfs_regs.svh"
module pfs_freq_select_bench;
    import pfs_pkg::*;

    // ======================================================================
    // Signals
    logic clk;
    logic rst_n;
    logic [4:0] strapCode;
    logic [7:0] regAddr;
    logic regWrEn;
    logic [7:0] regWrData;
    logic regRdEn;
    logic [7:0] regRdData;
    logic regRdValid;
    logic [7:0] cpuDividerNValue;
    logic [6:0] cpuDividerMValue;
    logic customFreqEnable;
    logic freqLoadPulse;
    logic [4:0] activeCode;
    logic softSourceActive;
    logic [11:0] cpuFreqTenths;
    logic [11:0] midRateClockGroupTenths;
    logic [11:0] pciFreqTenths;
    logic tableValid;
    logic [22:0] gearConstant;
    logic [40:0] row;
    int mismatches;
    int checked;

    // Rows: {code, cpu, mid-rate group, pci}, one per code in code order.
    logic [40:0] freqRows [32] = '{
        41'h00_618_30c_186, 41'h01_604_302_181, 41'h02_5f0_2f8_17c, 41'h03_5be_2df_170,
        41'h04_5a0_2d0_168, 41'h05_58c_2c6_163, 41'h06_564_2b2_159, 41'h07_550_2a8_154,
        41'h08_4d8_26c_136, 41'h09_4c4_262_131, 41'h0a_492_30c_186, 41'h0b_47e_2ff_17f,
        41'h0c_46a_2f1_179, 41'h0d_438_2d0_168, 41'h0e_41a_2bc_15e, 41'h0f_3fc_2a8_154,
        41'h10_000_000_000, 41'h11_000_000_000, 41'h12_000_000_000, 41'h13_7d0_29a_14d,
        41'h14_76c_2f8_17c, 41'h15_708_2d0_168, 41'h16_6a4_2a8_154, 41'h17_5dc_2ee_177,
        41'h18_578_2bc_15e, 41'h19_4b0_258_12c, 41'h1a_44c_2dd_14d, 41'h1b_29a_29a_14d,
        41'h1c_7d0_29a_14d, 41'h1d_682_29a_14d, 41'h1e_3e8_29a_14d, 41'h1f_535_29a_14d
    };

    // Register defaults as {offset, value}.
    logic [15:0] rstRows [6] = '{16'h0d00, 16'h0e00, 16'h0f03, 16'h1000, 16'h1100, 16'h1200};

    pfs_freq_select pfs_freq_select_inst (
        .clk(clk),
        .rst_n(rst_n),
        .strapFrequencyCode(strapCode),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regWrData(regWrData),
        .regRdEn(regRdEn),
        .regRdData(regRdData),
        .regRdValid(regRdValid),
        .cpuDividerNValue(cpuDividerNValue),
        .cpuDividerMValue(cpuDividerMValue),
        .customFreqEnable(customFreqEnable),
        .freqLoadPulse(freqLoadPulse),
        .activeCode(activeCode),
        .softSourceActive(softSourceActive),
        .cpuFreqTenths(cpuFreqTenths),
        .midRateClockGroupTenths(midRateClockGroupTenths),
        .pciFreqTenths(pciFreqTenths),
        .tableValid(tableValid),
        .gearConstant(gearConstant)
    );

    // ======================================================================
    // Clock and watchdog; the full run needs well under a thousand cycles.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    // ======================================================================
    // Tasks
    task automatic wrap_up();
        $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Case equality so an unknown output never passes as a match.
    task automatic check_out(input logic [35:0] got, input logic [35:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Returns at the edge that takes the write, so effects show right after it.
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        regAddr <= addr;
        regWrData <= data;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
        #1;
    endtask

    task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp, input string what);
        @(posedge clk);
        regAddr <= addr;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        check_out(regRdValid, 1'b1, "read valid");
        check_out(regRdData, exp, what);
    endtask

    // Holds reset for six cycles; strap pins must already carry the wanted code.
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic check_reset(input logic [4:0] strap);
        for (int i = 0; i < 6; i++) begin
            check_reg(rstRows[i][15:8], rstRows[i][7:0], "reset value");
        end
        check_reg(`PFS_OFF_STATUS, {3'b100, strap}, "status after reset");
        check_out(activeCode, strap, "strap code");
        check_out(softSourceActive, 1'b0, "strap source");
        check_out(customFreqEnable, 1'b0, "enable reset");
        check_out({cpuFreqTenths, midRateClockGroupTenths, pciFreqTenths},
            freqRows[strap][35:0], "strap freq");
    endtask

    // ======================================================================
    // Main sequence: reset, table loop, then hand-written cases.
    initial begin
        rst_n = 1'b0;
        strapCode = 5'h0b;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
        do_reset();
        check_reset(5'h0b);
        strapCode <= 5'h1f;
        $display("Test reset finished");
        for (int i = 0; i < 32; i++) begin
            row = freqRows[i];
            reg_write(`PFS_OFF_SEL_CTRL, {3'b001, row[40:36]});
            repeat (2) @(posedge clk);
            #1;
            check_out(activeCode, row[40:36], "soft code");
            check_out(softSourceActive, 1'b1, "soft source");
            check_out({cpuFreqTenths, midRateClockGroupTenths, pciFreqTenths},
                row[35:0], "table freq");
            check_out(tableValid, row[35:0] != 36'h0, "table valid");
            check_out(gearConstant, (row[35:0] != 36'h0) ? `PFS_GEAR_CONST : 23'h0,
                "gear");
        end
        $display("Test table loop finished");
        // Override cleared again: the latched strap wins, not the new pin level.
        reg_write(`PFS_OFF_SEL_CTRL, 8'h1f);
        repeat (2) @(posedge clk);
        #1;
        check_out(activeCode, 5'h0b, "latched strap");
        check_out(cpuFreqTenths, 12'h47e, "strap cpu");
        reg_write(`PFS_OFF_SEL_CTRL, 8'hff);
        check_reg(`PFS_OFF_SEL_CTRL, 8'h3f, "sel ctrl mask");
        $display("Test override finished");
        // N alone must not start a load; M does, in the very next cycle.
        reg_write(`PFS_OFF_N_VALUE, 8'ha5);
        check_out(freqLoadPulse, 1'b0, "no load on N");
        check_out(cpuDividerNValue, 8'ha5, "N value");
        reg_write(`PFS_OFF_M_VALUE, 8'h8a);
        check_out(freqLoadPulse, 1'b1, "load on M");
        check_out(customFreqEnable, 1'b1, "enable set");
        check_out(cpuDividerMValue, 7'h0a, "M value");
        @(posedge clk);
        #1;
        check_out(freqLoadPulse, 1'b0, "load one cycle");
        check_reg(`PFS_OFF_M_VALUE, 8'h8a, "M readback");
        check_reg(`PFS_OFF_STATUS, 8'hcb, "custom status");
        reg_write(`PFS_OFF_N_VALUE, 8'h5a);
        check_reg(`PFS_OFF_N_VALUE, 8'h5a, "N readback");
        reg_write(`PFS_OFF_M_VALUE, 8'h7f);
        check_out(customFreqEnable, 1'b0, "enable clear");
        check_out(freqLoadPulse, 1'b1, "load on M again");
        $display("Test divider finished");
        // Reserved, unmapped and read-only places.
        reg_write(`PFS_OFF_RSVD_A, 8'h03);
        check_reg(`PFS_OFF_RSVD_A, 8'h03, "reserved a");
        reg_write(8'h20, 8'hff);
        check_reg(8'h20, 8'h00, "unmapped");
        reg_write(`PFS_OFF_STATUS, 8'h00);
        check_reg(`PFS_OFF_STATUS, 8'h8b, "status read only");
        $display("Test reserved finished");
        // A second reset relatches the straps and restores every default.
        strapCode <= 5'h13;
        do_reset();
        check_reset(5'h13);
        $display("Test second reset finished");
        wrap_up();
    end
endmodule
